// >>> pbpc_pkg.sv
// Purpose: constants and carriers for the bridge port configuration bank
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   two identical per-bus spaces, bus B at a fixed stride
package pbpc_pkg;
	localparam int unsigned ADDR_W = 12;
	// byte address of the bus B space; bus A sits at zero
	localparam logic [ADDR_W-1:0] BUS_B_BASE = 12'h100;
	localparam logic [7:0] OFF_CLASS_WORD = 8'h08;
	localparam logic [7:0] OFF_LINE_WORD  = 8'h0C;
	localparam logic [7:0] OFF_PORT_CTRL  = 8'h40;
	localparam logic [7:0] OFF_CAPACITY   = 8'h48;
	// class code sits in bytes 9..11 of the word at 08h
	localparam int unsigned CLASS_LSB = 8;
	localparam logic [23:0] CLASS_CODE = 24'h060000;
	localparam logic [7:0]  LINE_SIZE_RST = 8'h08;
	localparam logic [23:0] CAP_WIDE   = 24'h302308;
	localparam logic [23:0] CAP_NARROW = 24'h182184;
	localparam logic [15:0] CTRL_RST   = 16'h2310;
	// software-writable bits of the port control word
	localparam logic [15:0] CTRL_WMASK = 16'h7FF0;
	localparam int unsigned B_LOCK     = 14;
	localparam int unsigned B_WACC     = 13;
	localparam int unsigned B_LINE_PF  = 12;
	localparam int unsigned B_WORD_PF  = 11;
	localparam int unsigned B_BLOCK    = 10;
	localparam int unsigned B_IOMASK   = 9;
	localparam int unsigned B_PASS     = 8;
	localparam int unsigned B_MERGE    = 7;
	localparam int unsigned B_RESTREAM = 6;
	localparam int unsigned B_PF_LSB   = 4;
	localparam int unsigned B_EXT_ARB  = 3;
	localparam int unsigned B_WIDE     = 2;
	localparam int unsigned B_GEAR     = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic        lock_enable;
		logic        write_accept_enable;
		logic        line_prefetch_enable;
		logic        word_prefetch_enable;
		logic        block_requests;
		logic        io_mask;
		logic        write_pass_read;
		logic        write_merge_enable;
		logic        restream_enable;
		logic [1:0]  prefetch_size;
	} pbpc_ctrl_type;

	typedef struct packed {
		logic        external_arbiter_strap;
		logic        wide_bus_strap;
		logic        clock_ratio_strap;
	} pbpc_strap_type;
endpackage

// >>> pbpc_port_config.sv
// Purpose: per-bus configuration bank of a host-to-PCI expander bridge
// Assumes: straps stable after reset; synchronous inputs at ref_clk
// Notes:   bus B space vanishes (SLVERR) in wide-bus mode

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - two identical, independent register spaces, one per PCI bus.
// - in wide-bus mode only bus A space answers; bus B refused.
// - capacity register read-only, 302308h wide, 182184h narrow.
// - bits 23:18 write queue depth, 6 narrow, 12 wide.
// - bits 17:12 read queue depth, 2 in both modes.
// - bits 11:6 write buffers of 32 bytes, 6 narrow, 12 wide.
// - bits 5:0 read buffers of 32 bytes, 4 narrow, 8 wide.
// - class code read-only, base class 06h, other bytes zero.
// - line size read/write, resets 08h; software writes only 08h.
// - bit 14 with internal arbitration keeps grants to lock owner only.
// - bit 13 clear holds posted write accept asserted; resets to one.
// - bits 12 and 11 make line and sub-line reads prefetchable.
// - bit 10 under internal arbitration blocks all requests and grants.
// - bit 9, reset one, zeroes upper I/O address bits.
// - bit 8, reset one, lets writes pass retried reads.
// - bit 7 enables merging of sequential outbound writes.
// - bit 6 keeps delayed-read data after disconnect.
// - bits 5:4 prefetch length 16/32/64 dwords, reset 01.
// - bit 3 reflects this bus's external arbiter strap.
// - bit 2 reflects the wide-bus strap.
// - bit 1 reflects the clock ratio strap, expected zero.
module pbpc_port_config (
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	input  wire logic [pbpc_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [pbpc_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          ext_arb_strap_a,
	input  wire logic                          ext_arb_strap_b,
	input  wire logic                          wide_bus_strap,
	input  wire logic                          clock_ratio_strap,
	input  wire logic [1:0]                    lock_established,
	output pbpc_pkg::pbpc_ctrl_type            ctrl_a,
	output pbpc_pkg::pbpc_ctrl_type            ctrl_b,
	output logic [1:0]                         arb_lock_hold,
	output logic [1:0]                         arb_block,
	output logic [1:0]                         posted_write_accept_force,
	output logic [1:0]                         line_prefetch_enable,
	output logic [1:0]                         word_prefetch_enable,
	output logic [1:0]                         write_merge_enable,
	output logic [1:0]                         io_addr_mask
);

	localparam int unsigned NBUS = 2;

	typedef struct packed {
		logic                         aw_full;
		logic [pbpc_pkg::ADDR_W-1:0]  aw_addr;
		logic                         w_full;
		logic [31:0]                  w_data;
		logic [3:0]                   w_strb;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		logic                         straps_taken;
		pbpc_pkg::pbpc_strap_type     strap_a;
		pbpc_pkg::pbpc_strap_type     strap_b;
		logic [NBUS-1:0][7:0]         line_size;
		pbpc_pkg::pbpc_ctrl_type [NBUS-1:0] ctrl;
		logic [NBUS-1:0]              lock_hold;
		logic [NBUS-1:0]              block;
	} pbpc_state_type;

	pbpc_state_type state;
	pbpc_state_type next_state;

	localparam pbpc_pkg::pbpc_ctrl_type CTRL_RST_S = pbpc_pkg::CTRL_RST[14:4];

	//////////////////////////////////////////////////////////////////////////
	// read-back image of one bus space
	function automatic logic [31:0] read_word(
		input logic [7:0]                 off,
		input logic [7:0]                 ls,
		input pbpc_pkg::pbpc_ctrl_type    c,
		input pbpc_pkg::pbpc_strap_type   s
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (off)
			pbpc_pkg::OFF_CLASS_WORD: v = {pbpc_pkg::CLASS_CODE, 8'h00};
			pbpc_pkg::OFF_LINE_WORD:  v = {24'h000000, ls};
			pbpc_pkg::OFF_PORT_CTRL:  v = {16'h0000, 1'b0, c, s, 1'b0};
			pbpc_pkg::OFF_CAPACITY:   v = {8'h00, (s.wide_bus_strap ?
				pbpc_pkg::CAP_WIDE : pbpc_pkg::CAP_NARROW)};
			default:                  v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic known_off(input logic [7:0] off);
		return off == pbpc_pkg::OFF_CLASS_WORD || off == pbpc_pkg::OFF_LINE_WORD
			|| off == pbpc_pkg::OFF_PORT_CTRL || off == pbpc_pkg::OFF_CAPACITY;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic                         wbus;
		logic [7:0]                   woff;
		logic                         wok;
		logic                         rbus;
		logic [7:0]                   roff;
		logic [15:0]                  cw;
		logic [15:0]                  cn;
		pbpc_pkg::pbpc_strap_type     rs;
		wbus = 1'b0;
		woff = 8'h00;
		wok = 1'b0;
		rbus = 1'b0;
		roff = 8'h00;
		cw = 16'h0000;
		cn = 16'h0000;
		rs = state.strap_a;
		next_state = state;
		if (!state.straps_taken) begin
			next_state.straps_taken = 1'b1;
			next_state.strap_a = {ext_arb_strap_a, wide_bus_strap, clock_ratio_strap};
			next_state.strap_b = {ext_arb_strap_b, wide_bus_strap, clock_ratio_strap};
		end
		if (s_axi_awvalid && !state.aw_full) begin
			next_state.aw_full = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state.w_full) begin
			next_state.w_full = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_state.bvalid = 1'b0;
		// write executes once both halves held and no response pending
		if (state.aw_full && state.w_full && !state.bvalid) begin
			wbus = state.aw_addr >= pbpc_pkg::BUS_B_BASE;
			woff = 8'(state.aw_addr - (wbus ? pbpc_pkg::BUS_B_BASE : 12'h000));
			woff[1:0] = 2'h0;
			wok = state.aw_addr < 12'(2 * pbpc_pkg::BUS_B_BASE) && known_off(woff)
				&& !(wbus && state.strap_a.wide_bus_strap);
			next_state.aw_full = 1'b0;
			next_state.w_full = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = wok ? pbpc_pkg::RESP_OKAY : pbpc_pkg::RESP_SLVERR;
			if (wok && woff == pbpc_pkg::OFF_LINE_WORD && state.w_strb[0])
				next_state.line_size[wbus] = state.w_data[7:0];
			if (wok && woff == pbpc_pkg::OFF_PORT_CTRL) begin
				cw = {1'b0, state.ctrl[wbus], 4'h0};
				cn = state.w_data[15:0];
				if (!state.w_strb[0])
					cn[7:0] = cw[7:0];
				if (!state.w_strb[1])
					cn[15:8] = cw[15:8];
				cn = cn & pbpc_pkg::CTRL_WMASK;
				next_state.ctrl[wbus] = cn[14:4];
			end
		end
		if (s_axi_rvalid && s_axi_rready)
			next_state.rvalid = 1'b0;
		if (s_axi_arvalid && !state.rvalid) begin
			rbus = s_axi_araddr >= pbpc_pkg::BUS_B_BASE;
			roff = 8'(s_axi_araddr - (rbus ? pbpc_pkg::BUS_B_BASE : 12'h000));
			roff[1:0] = 2'h0;
			rs = rbus ? state.strap_b : state.strap_a;
			next_state.rvalid = 1'b1;
			if (s_axi_araddr < 12'(2 * pbpc_pkg::BUS_B_BASE) && known_off(roff)
				&& !(rbus && state.strap_a.wide_bus_strap)) begin
				next_state.rdata = read_word(roff, state.line_size[rbus],
					state.ctrl[rbus], rs);
				next_state.rresp = pbpc_pkg::RESP_OKAY;
			end else begin
				next_state.rdata = 32'h0000_0000;
				next_state.rresp = pbpc_pkg::RESP_SLVERR;
			end
		end
		// arbiter steering; external arbitration disables both controls
		next_state.lock_hold[0] = state.ctrl[0].lock_enable && lock_established[0]
			&& !state.strap_a.external_arbiter_strap;
		next_state.lock_hold[1] = state.ctrl[1].lock_enable && lock_established[1]
			&& !state.strap_b.external_arbiter_strap;
		next_state.block[0] = state.ctrl[0].block_requests
			&& !state.strap_a.external_arbiter_strap;
		next_state.block[1] = state.ctrl[1].block_requests
			&& !state.strap_b.external_arbiter_strap;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
			state.line_size <= {NBUS{pbpc_pkg::LINE_SIZE_RST}};
			state.ctrl <= {NBUS{CTRL_RST_S}};
		end else begin
			state <= next_state;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = !state.aw_full;
	assign s_axi_wready  = !state.w_full;
	assign s_axi_bvalid  = state.bvalid;
	assign s_axi_bresp   = state.bresp;
	assign s_axi_arready = !state.rvalid;
	assign s_axi_rvalid  = state.rvalid;
	assign s_axi_rdata   = state.rdata;
	assign s_axi_rresp   = state.rresp;
	assign ctrl_a        = state.ctrl[0];
	assign ctrl_b        = state.ctrl[1];
	assign arb_lock_hold = state.lock_hold;
	assign arb_block     = state.block;

	genvar gi;
	generate
		for (gi = 0; gi < NBUS; gi++) begin : g_bus
			assign posted_write_accept_force[gi] = !state.ctrl[gi].write_accept_enable;
			assign line_prefetch_enable[gi] = state.ctrl[gi].line_prefetch_enable;
			assign word_prefetch_enable[gi] = state.ctrl[gi].word_prefetch_enable;
			assign write_merge_enable[gi]   = state.ctrl[gi].write_merge_enable;
			assign io_addr_mask[gi]         = state.ctrl[gi].io_mask;
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	wire b_hit = s_axi_araddr >= pbpc_pkg::BUS_B_BASE;

	property p_b_refused;
		@(posedge ref_clk) disable iff (!nrst)
		(s_axi_arvalid && s_axi_arready && b_hit && state.strap_a.wide_bus_strap
			&& state.straps_taken) |=> s_axi_rresp == pbpc_pkg::RESP_SLVERR;
	endproperty
	b_side_off_a: assert property (p_b_refused) else $error("bus B answered in wide mode");

	cap_value_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(s_axi_arvalid && s_axi_arready && !b_hit
			&& s_axi_araddr[7:0] == pbpc_pkg::OFF_CAPACITY && state.straps_taken)
		|=> s_axi_rdata[23:0] == (state.strap_a.wide_bus_strap ? 24'h302308 : 24'h182184))
		else $error("capacity value wrong");

	class_value_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(s_axi_arvalid && s_axi_arready && !b_hit && s_axi_araddr[7:0] == 8'h08)
		|=> s_axi_rdata == 32'h0600_0000) else $error("class code wrong");

	ctrl_rsvd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h40)
		|=> s_axi_rdata[15] == 1'b0 && s_axi_rdata[0] == 1'b0)
		else $error("reserved control bit set");

	block_ext_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		state.strap_a.external_arbiter_strap |=> !arb_block[0])
		else $error("block active under external arbitration");

	block_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state.ctrl[0].block_requests && !state.strap_a.external_arbiter_strap)
		|=> arb_block[0]) else $error("block request not applied");

	lock_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		arb_lock_hold[1] |-> $past(lock_established[1]) && $past(state.ctrl[1].lock_enable))
		else $error("lock hold without cause");

	// lock steering must stay dormant on a bus that uses the external arbiter
	lock_ext_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		state.strap_b.external_arbiter_strap |=> !arb_lock_hold[1])
		else $error("lock hold under external arbitration");

	line_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == {4'h0, pbpc_pkg::OFF_LINE_WORD})
		|=> s_axi_rdata == {24'h000000, $past(state.line_size[0])})
		else $error("line size read back wrong");

	sequence s_wr_done;
		state.aw_full && state.w_full && !state.bvalid;
	endsequence
	write_resp_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_wr_done |=> s_axi_bvalid ##0 !s_axi_awready == 1'b0)
		else $error("write not answered");

	wr_refused_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(s_wr_done and (state.aw_addr >= pbpc_pkg::BUS_B_BASE
			&& state.strap_a.wide_bus_strap))
		|=> s_axi_bresp == pbpc_pkg::RESP_SLVERR)
		else $error("bus B write taken in wide mode");

	accept_force_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		posted_write_accept_force[0] != ctrl_a.write_accept_enable)
		else $error("write accept force wrong");
endmodule

// >>> pbpc_host_model.sv
// Purpose: configuration software as an AXI4-Lite master for the bank
// Assumes: one write and one read at a time, all registers 32-bit words
// Notes:   tasks start one edge late so no signal is driven twice per step
module pbpc_host_model (
	input  wire logic                        ref_clk,
	output logic [pbpc_pkg::ADDR_W-1:0]      s_axi_awaddr,
	output logic                             s_axi_awvalid,
	input  wire logic                        s_axi_awready,
	output logic [31:0]                      s_axi_wdata,
	output logic [3:0]                       s_axi_wstrb,
	output logic                             s_axi_wvalid,
	input  wire logic                        s_axi_wready,
	input  wire logic [1:0]                  s_axi_bresp,
	input  wire logic                        s_axi_bvalid,
	output logic                             s_axi_bready,
	output logic [pbpc_pkg::ADDR_W-1:0]      s_axi_araddr,
	output logic                             s_axi_arvalid,
	input  wire logic                        s_axi_arready,
	input  wire logic [31:0]                 s_axi_rdata,
	input  wire logic [1:0]                  s_axi_rresp,
	input  wire logic                        s_axi_rvalid,
	output logic                             s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	task automatic write_word(input logic [pbpc_pkg::ADDR_W-1:0] addr,
		input logic [31:0] data, output logic [1:0] resp);
		@(posedge ref_clk);
		s_axi_awaddr <= addr;
		s_axi_wdata <= data;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic read_word(input logic [pbpc_pkg::ADDR_W-1:0] addr,
		output logic [31:0] data, output logic [1:0] resp);
		@(posedge ref_clk);
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// >>> pbpc_port_config_bench.sv
// Purpose: register and control-output checks of the port configuration bank
// Assumes: straps change only while reset is held
// Notes:   bus B is straped to external arbitration in the narrow run
module pbpc_port_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] OK = pbpc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = pbpc_pkg::RESP_SLVERR;
	localparam logic [11:0] B = pbpc_pkg::BUS_B_BASE;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic strap_a = 1'b0, strap_b = 1'b1, strap_wide = 1'b0, strap_gear = 1'b0;
	logic [1:0] lock_established = 2'h0;
	wire logic [11:0] awaddr, araddr;
	wire logic [31:0] wdata, rdata;
	wire logic [3:0] wstrb;
	wire logic [1:0] bresp, rresp;
	wire logic awvalid, awready, wvalid, wready, bvalid, bready;
	wire logic arvalid, arready, rvalid, rready;
	pbpc_pkg::pbpc_ctrl_type ctrl_a, ctrl_b;
	logic [1:0] lock_hold, blk, force_acc, line_pf, word_pf, merge, io_mask;
	int errors = 0;
	int comparisons = 0;
	logic [31:0] rd;
	logic [1:0] rs;
	always #5 ref_clk = ~ref_clk;
	pbpc_host_model host (.ref_clk(ref_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	pbpc_port_config dut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_arb_strap_a(strap_a), .ext_arb_strap_b(strap_b),
		.wide_bus_strap(strap_wide), .clock_ratio_strap(strap_gear),
		.lock_established(lock_established), .ctrl_a(ctrl_a), .ctrl_b(ctrl_b),
		.arb_lock_hold(lock_hold), .arb_block(blk), .posted_write_accept_force(force_acc),
		.line_prefetch_enable(line_pf), .word_prefetch_enable(word_pf),
		.write_merge_enable(merge), .io_addr_mask(io_mask));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		host.read_word(a, rd, rs);
		check("read data", rd, exp);
		check("read response", {30'h0, rs}, {30'h0, er});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		host.write_word(a, d, rs);
		check("write response", {30'h0, rs}, {30'h0, er});
	endtask
	// outputs packed as lock, block, force, line, word, merge, io
	task automatic out_chk(input logic [13:0] exp);
		repeat (2) @(posedge ref_clk);
		check("control outputs", {18'h0, lock_hold, blk, force_acc, line_pf, word_pf, merge,
			io_mask}, {18'h0, exp});
	endtask
	task automatic do_reset;
		nrst <= 1'b0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		final_report();
	end
	initial begin
		do_reset();
		rd_chk(12'h040, 32'h0000_2310, OK);
		rd_chk(B + 12'h040, 32'h0000_2318, OK);
		rd_chk(12'h048, 32'h0018_2184, OK);
		rd_chk(12'h008, 32'h0600_0000, OK);
		rd_chk(12'h00C, 32'h0000_0008, OK);
		wr(12'h040, 32'hFFFF_FFFF, OK);
		rd_chk(12'h040, 32'h0000_7FF0, OK);
		check("ctrl a", {21'h0, ctrl_a}, 32'h0000_07FF);
		check("ctrl b", {21'h0, ctrl_b}, 32'h0000_0231);
		lock_established <= 2'h3;
		out_chk(14'b01_01_00_01_01_01_11);
		// bus B uses the external arbiter, so lock and block must stay dormant
		wr(B + 12'h040, 32'h0000_4400, OK);
		out_chk(14'b01_01_10_01_01_01_01);
		for (int i = 0; i < 4; i++) begin
			wr(12'h040, 32'(i) << 4, OK);
			rd_chk(12'h040, 32'(i) << 4, OK);
			check("prefetch size", {30'h0, ctrl_a.prefetch_size}, 32'(i));
		end
		out_chk(14'b00_00_11_00_00_00_00);
		check("restream a", {31'h0, ctrl_a.restream_enable}, 32'h0);
		check("pass a", {31'h0, ctrl_a.write_pass_read}, 32'h0);
		wr(12'h00C, 32'h0000_0008, OK);
		rd_chk(12'h00C, 32'h0000_0008, OK);
		wr(12'h048, 32'hFFFF_FFFF, OK);
		rd_chk(12'h048, 32'h0018_2184, OK);
		wr(12'h008, 32'h0000_0000, OK);
		rd_chk(12'h008, 32'h0600_0000, OK);
		rd_chk(12'h200, 32'h0000_0000, ERR);
		wr(12'h200, 32'h0000_0000, ERR);
		strap_wide <= 1'b1;
		strap_gear <= 1'b1;
		strap_a <= 1'b1;
		do_reset();
		rd_chk(12'h040, 32'h0000_231E, OK);
		rd_chk(12'h048, 32'h0030_2308, OK);
		rd_chk(B + 12'h048, 32'h0000_0000, ERR);
		wr(B + 12'h040, 32'h0000_0000, ERR);
		wr(12'h040, 32'h0000_4400, OK);
		out_chk(14'b00_00_01_00_00_00_10);
		final_report();
	end
endmodule
